// ### verilog/scab_map.vh
/*
  Register map and field layout of the switched-capacitor type-A block
  second control register (four instances).
  Assumes: included by bare name from the design files, 8-bit register port.
*/
`ifndef SCAB_MAP_VH
`define SCAB_MAP_VH

// number of type-A blocks and register width
`define SCAB_NBLK        4
`define SCAB_DW          8
`define SCAB_AW          8

// second control register offsets, same in both banks
`define SCAB_CR2_B10     8'h82
`define SCAB_CR2_B12     8'h8A
`define SCAB_CR2_B21     8'h96
`define SCAB_CR2_B23     8'h9E

// first control register offsets, held elsewhere, read as zero here
`define SCAB_CR1_B10     8'h81
`define SCAB_CR1_B12     8'h89
`define SCAB_CR1_B21     8'h95
`define SCAB_CR1_B23     8'h9D

// field positions
`define SCAB_GATE_BIT    7
`define SCAB_CMPEN_BIT   6
`define SCAB_OFFC_BIT    5
`define SCAB_CAP_MSB     4
`define SCAB_CAP_LSB     0
`define SCAB_CAP_W       5

// reset value and capacitor array size
`define SCAB_CR2_RST     8'h00
`define SCAB_UNITS       31

`endif

// ### verilog/scab_ctrl2.v
/*
  Second control register of four switched-capacitor type-A blocks and the
  switch-gating logic that the register steers: column bus gate, comparator
  line, offset-cancel switches and C-branch capacitor unit select.
  Assumes: single clock mclk, phase and comparator inputs come from the analog
  clock generator and comparators (asynchronous), phase_swap_select comes from
  the first control register logic on mclk. The bank bit is not decoded.
*/
// Contract
// - column gate field 0: analog column bus drive stays high impedance
// - column gate field 1: output connects, form picked by phase-swap select
// - swap 0: connect only in late part of second phase
// - swap 1: drive the column bus continuously
// - comparator enable puts latched result on comparator bus, else withholds it
// - undriven comparator bus reads low
// - comparator sampled on first phase rise, held through second phase
// - offset cancel 1: short during first phase; caps ground then amp input
// - offset cancel 0: short open, caps on amp input in both phases
// - offset cancel also enables the summing-node switch pair
// - offset cancel field exported to feedback switch one logic
// - capacitor size field is a binary count of 0 to 31 units
// - four independent registers at 82h, 8Ah, 96h, 9Eh in both banks
`include "scab_map.vh"

module scab_ctrl2 (
  // clock, reset, enable
  input  wire         mclk,
  input  wire         nrst,
  input  wire         ce,
  // register port
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  // analog timing and comparator inputs, one bit per block
  input  wire [3:0]   first_phase,
  input  wire [3:0]   second_phase,
  input  wire [3:0]   sample_window,
  input  wire [3:0]   comp_result,
  // from first control register logic, same clock
  input  wire [3:0]   phase_swap_select,
  // column bus switches
  output reg  [3:0]   col_bus_oe,
  output reg  [3:0]   comp_line_out,
  output reg  [3:0]   comp_line_oe,
  output reg  [3:0]   comp_latched,
  // offset-cancel switches
  output reg  [3:0]   offset_short_sw,
  output reg  [3:0]   cap_to_gnd,
  output reg  [3:0]   cap_to_amp,
  output reg  [3:0]   sum_node_sw,
  output reg  [3:0]   offset_cancel_enable,
  // capacitor array select
  output reg  [19:0]  c_branch_cap_size,
  output reg  [123:0] c_unit_en
);

  // address to one-hot block select
  function [3:0] blk_sel;
    input [7:0] a;
    begin
      case (a)
        `SCAB_CR2_B10: blk_sel = 4'h1;
        `SCAB_CR2_B12: blk_sel = 4'h2;
        `SCAB_CR2_B21: blk_sel = 4'h4;
        `SCAB_CR2_B23: blk_sel = 4'h8;
        default:       blk_sel = 4'h0;
      endcase
    end
  endfunction

  // binary count to thermometer of unit capacitors
  function [30:0] unit_thermo;
    input [4:0] n;
    integer     k;
    begin
      unit_thermo = 31'h00000000;
      for (k = 0; k < `SCAB_UNITS; k = k + 1)
      begin
        unit_thermo[k] = (k < n);
      end
    end
  endfunction

  // register storage
  reg  [7:0]  ctl_q [0:3];
  reg  [3:0]  fph_s1_q;
  reg  [3:0]  fph_s2_q;
  reg  [3:0]  fph_prev_q;
  reg  [3:0]  sph_s1_q;
  reg  [3:0]  sph_s2_q;
  reg  [3:0]  swin_s1_q;
  reg  [3:0]  swin_s2_q;
  reg  [3:0]  cmp_s1_q;
  reg  [3:0]  cmp_s2_q;
  reg  [3:0]  cmp_hold_q;

  wire [3:0]  wr_sel;
  wire [3:0]  rd_sel;
  wire [3:0]  fph_rise;
  reg  [7:0]  rd_mux;

  assign wr_sel   = reg_wr ? blk_sel(reg_addr) : 4'h0;
  assign rd_sel   = reg_rd ? blk_sel(reg_addr) : 4'h0;
  // edge taken from second stage only, never from the first
  assign fph_rise = fph_s2_q & ~fph_prev_q;

  // read mux, unmapped offsets read zero
  always @*
  begin
    case (rd_sel)
      4'h1:    rd_mux = ctl_q[0];
      4'h2:    rd_mux = ctl_q[1];
      4'h4:    rd_mux = ctl_q[2];
      4'h8:    rd_mux = ctl_q[3];
      default: rd_mux = 8'h00;
    endcase
  end

  // register port: data stand one cycle after the read strobe only
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (ce)
    begin
      reg_rdata <= rd_mux;
    end
  end

  // two-stage synchronisers for analog-side inputs
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      fph_s1_q   <= 4'h0;
      fph_s2_q   <= 4'h0;
      fph_prev_q <= 4'h0;
      sph_s1_q   <= 4'h0;
      sph_s2_q   <= 4'h0;
      swin_s1_q  <= 4'h0;
      swin_s2_q  <= 4'h0;
      cmp_s1_q   <= 4'h0;
      cmp_s2_q   <= 4'h0;
    end
    else if (ce)
    begin
      fph_s1_q   <= first_phase;
      fph_s2_q   <= fph_s1_q;
      fph_prev_q <= fph_s2_q;
      sph_s1_q   <= second_phase;
      sph_s2_q   <= sph_s1_q;
      swin_s1_q  <= sample_window;
      swin_s2_q  <= swin_s1_q;
      cmp_s1_q   <= comp_result;
      cmp_s2_q   <= cmp_s1_q;
    end
  end

  // per-block field vectors, lifted out of the register words
  reg  [3:0]  gate_en;
  reg  [3:0]  cmp_en;
  reg  [3:0]  offc_en;
  reg  [19:0] cap_sz;
  // loop indices, one per process so each keeps a single driver
  integer     fj;
  integer     rj;
  integer     lj;
  integer     cj;
  integer     mj;
  integer     oj;
  integer     uj;

  // column bus gate: swap 1 drives steadily, swap 0 only in the late window
  function col_gate;
    input en;
    input swap;
    input sph;
    input win;
    begin
      if (!en)
      begin
        col_gate = 1'b0;
      end
      else if (swap)
      begin
        col_gate = 1'b1;
      end
      else
      begin
        col_gate = sph & win;
      end
    end
  endfunction

  // field split of all four register words
  always @*
  begin
    gate_en = 4'h0;
    cmp_en  = 4'h0;
    offc_en = 4'h0;
    cap_sz  = 20'h00000;
    for (fj = 0; fj < `SCAB_NBLK; fj = fj + 1)
    begin
      gate_en[fj]       = ctl_q[fj][`SCAB_GATE_BIT];
      cmp_en[fj]        = ctl_q[fj][`SCAB_CMPEN_BIT];
      offc_en[fj]       = ctl_q[fj][`SCAB_OFFC_BIT];
      cap_sz[fj*5 +: 5] = ctl_q[fj][`SCAB_CAP_MSB:`SCAB_CAP_LSB];
    end
  end

  // control registers, all fields read/write
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (rj = 0; rj < `SCAB_NBLK; rj = rj + 1)
      begin
        ctl_q[rj] <= `SCAB_CR2_RST;
      end
    end
    else if (ce)
    begin
      for (rj = 0; rj < `SCAB_NBLK; rj = rj + 1)
      begin
        if (wr_sel[rj])
        begin
          ctl_q[rj] <= reg_wdata;
        end
      end
    end
  end

  // comparator latch: sampled on first-phase rise, held through second phase
  // result taken from the same sync depth as the phase, so both stay aligned
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      cmp_hold_q <= 4'h0;
    end
    else if (ce)
    begin
      for (lj = 0; lj < `SCAB_NBLK; lj = lj + 1)
      begin
        if (fph_rise[lj])
        begin
          cmp_hold_q[lj] <= cmp_s2_q[lj];
        end
      end
    end
  end

  // column bus gate, registered so the analog side sees no glitches
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      col_bus_oe <= 4'h0;
    end
    else if (ce)
    begin
      for (cj = 0; cj < `SCAB_NBLK; cj = cj + 1)
      begin
        col_bus_oe[cj] <= col_gate(gate_en[cj], phase_swap_select[cj], sph_s2_q[cj], swin_s2_q[cj]);
      end
    end
  end

  // comparator line: low when withheld so an idle comparator bus reads low
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (mj = 0; mj < `SCAB_NBLK; mj = mj + 1)
      begin
        comp_line_out[mj] <= 1'b0;
        comp_line_oe[mj]  <= 1'b0;
        comp_latched[mj]  <= 1'b0;
      end
    end
    else if (ce)
    begin
      for (mj = 0; mj < `SCAB_NBLK; mj = mj + 1)
      begin
        comp_line_out[mj] <= cmp_en[mj] & cmp_hold_q[mj];
        comp_line_oe[mj]  <= cmp_en[mj];
        comp_latched[mj]  <= cmp_hold_q[mj];
      end
    end
  end

  // offset-cancel switches follow the synchronised phases
  // phases lag the pins by the sync depth; the analog side tolerates it
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (oj = 0; oj < `SCAB_NBLK; oj = oj + 1)
      begin
        offset_short_sw[oj]      <= 1'b0;
        cap_to_gnd[oj]           <= 1'b0;
        cap_to_amp[oj]           <= 1'b0;
        sum_node_sw[oj]          <= 1'b0;
        offset_cancel_enable[oj] <= 1'b0;
      end
    end
    else if (ce)
    begin
      for (oj = 0; oj < `SCAB_NBLK; oj = oj + 1)
      begin
        offset_short_sw[oj]      <= offc_en[oj] & fph_s2_q[oj];
        cap_to_gnd[oj]           <= offc_en[oj] & fph_s2_q[oj];
        cap_to_amp[oj]           <= ~offc_en[oj] | sph_s2_q[oj];
        sum_node_sw[oj]          <= offc_en[oj];
        offset_cancel_enable[oj] <= offc_en[oj];
      end
    end
  end

  // capacitor select: binary code and unit thermometer per block
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (uj = 0; uj < `SCAB_NBLK; uj = uj + 1)
      begin
        c_branch_cap_size[uj*5 +: 5] <= 5'h00;
        c_unit_en[uj*31 +: 31]       <= 31'h00000000;
      end
    end
    else if (ce)
    begin
      for (uj = 0; uj < `SCAB_NBLK; uj = uj + 1)
      begin
        c_branch_cap_size[uj*5 +: 5] <= cap_sz[uj*5 +: 5];
        c_unit_en[uj*31 +: 31]       <= unit_thermo(cap_sz[uj*5 +: 5]);
      end
    end
  end

endmodule // scab_ctrl2

// ### verification/scab_analog_model.sv
/*
  Analog side of the four type-A blocks: phase generator and comparators.
  Assumes: runs from mclk, 32-cycle period, phases never overlap.
*/
module scab_analog_model (
  // clock
  input  wire       mclk,
  // phases, sample window, comparator
  output reg  [3:0] first_phase,
  output reg  [3:0] second_phase,
  output reg  [3:0] sample_window,
  output reg  [3:0] comp_result
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] cnt_q;
  initial {first_phase, second_phase, sample_window, comp_result, cnt_q} = 24'h000000;
  always @(posedge mclk)
  begin
    cnt_q         <= cnt_q + 8'h01;
    first_phase   <= {4{cnt_q[4:0] < 5'h09}};
    second_phase  <= {4{cnt_q[4:0] >= 5'h0A && cnt_q[4:0] < 5'h13}};
    sample_window <= {4{cnt_q[4:0] >= 5'h0E && cnt_q[4:0] < 5'h13}};
    // comparator moves mid second phase, far from the latch point
    if (cnt_q[4:0] == 5'h0C)
      comp_result <= {4{cnt_q[5] ^ cnt_q[7]}};
  end
endmodule // scab_analog_model

// ### verification/scab_ctrl2_chk.sv
/*
  Checker of register timing and block 0 (82h) switch gating.
  Assumes: bound to scab_ctrl2, ce held high.
*/
module scab_ctrl2_chk (
  // clock and register port
  input wire        mclk,
  input wire        nrst,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  // analog side
  input wire [3:0]  first_phase,
  input wire [3:0]  second_phase,
  input wire [3:0]  sample_window,
  input wire [3:0]  comp_result,
  input wire [3:0]  phase_swap_select,
  // switches
  input wire [3:0]  col_bus_oe,
  input wire [3:0]  comp_line_out,
  input wire [3:0]  comp_line_oe,
  input wire [3:0]  comp_latched,
  input wire [3:0]  offset_short_sw,
  input wire [3:0]  cap_to_gnd,
  input wire [3:0]  cap_to_amp,
  input wire [3:0]  offset_cancel_enable,
  input wire [19:0] c_branch_cap_size
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // a write to 82h not overtaken by another one
  sequence wr0;
    reg_wr && reg_addr == 8'h82 ##1 !(reg_wr && reg_addr == 8'h82);
  endsequence
  AST_RDBACK: assert property (reg_wr && reg_addr == 8'h82 ##1 reg_rd && reg_addr == 8'h82
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("read back differs");
  AST_GATE_OFF: assert property (wr0 |=> $past(reg_wdata[7], 2) || !col_bus_oe[0])
    else $error("column bus driven while gated off");
  AST_SWAP_ON: assert property (wr0 ##0 phase_swap_select[0]
    |=> col_bus_oe[0] == $past(reg_wdata[7], 2)) else $error("swap drive wrong");
  AST_CMP_EN: assert property (wr0 |=> comp_line_oe[0] == $past(reg_wdata[6], 2)
    && (comp_line_oe[0] || !comp_line_out[0])) else $error("comparator line wrong");
  AST_OFFC_FIELD: assert property (wr0 |=> offset_cancel_enable[0] == $past(reg_wdata[5], 2))
    else $error("offset cancel copy wrong");
  AST_CAP_FIELD: assert property (wr0 |=> c_branch_cap_size[4:0] == $past(reg_wdata[4:0], 2))
    else $error("cap size wrong");
  AST_OFFC_OFF: assert property ((nrst && !offset_cancel_enable[0]) [*2]
    |-> !offset_short_sw[0] && !cap_to_gnd[0] && cap_to_amp[0]) else $error("short closed while off");
  AST_SHORT_ON: assert property ((first_phase[0] && offset_cancel_enable[0]) [*5]
    |-> offset_short_sw[0] && cap_to_gnd[0] && !cap_to_amp[0]) else $error("short open in first phase");
  AST_SAMPLE_GATE: assert property (col_bus_oe[0] && !$past(phase_swap_select[0])
    |-> $past(second_phase[0] && sample_window[0], 3)) else $error("drive outside window");
  AST_CMP_LATCH: assert property ($rose(first_phase[0])
    |-> ##4 comp_latched[0] == $past(comp_result[0], 4)) else $error("latch wrong");
  cover property (col_bus_oe[0] && !phase_swap_select[0]);
  cover property (offset_short_sw[0]);
  cover property (comp_line_out[0]);
endmodule // scab_ctrl2_chk

bind scab_ctrl2 scab_ctrl2_chk i_chk (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .first_phase, .second_phase, .sample_window, .comp_result, .phase_swap_select, .col_bus_oe,
  .comp_line_out, .comp_line_oe, .comp_latched, .offset_short_sw, .cap_to_gnd, .cap_to_amp, .offset_cancel_enable,
  .c_branch_cap_size);

// ### verification/test_sc_block_switch_control.sv
/*
  Testbench of the four type-A second control registers.
  Assumes: scab_ctrl2 and the analog model, ce tied high.
*/
module test_sc_block_switch_control;
  timeunit 1ns;
  timeprecision 1ns;
  reg           mclk = 1'b0;
  reg           nrst = 1'b0;
  reg  [7:0]    reg_addr = 8'h00;
  reg  [7:0]    reg_wdata = 8'h00;
  reg           reg_wr = 1'b0;
  reg           reg_rd = 1'b0;
  reg  [3:0]    phase_swap_select = 4'h0;
  reg  [7:0]    shadow [0:3];
  reg  [7:0]    d;
  wire [7:0]    reg_rdata;
  wire [3:0]    first_phase, second_phase, sample_window, comp_result, col_bus_oe, comp_line_out;
  wire [3:0]    comp_line_oe, offset_short_sw, sum_node_sw, offset_cancel_enable;
  wire [3:0]    comp_latched, cap_to_gnd, cap_to_amp;
  integer       gnds, amps, cmpbad;
  wire [19:0]   c_branch_cap_size;
  wire [123:0]  c_unit_en;
  integer       mismatches = 0, compares = 0, seed = 32'h6184, i, b, hits, shorts;
  always #5 mclk = ~mclk;
  scab_analog_model i_ana (.mclk, .first_phase, .second_phase, .sample_window, .comp_result);
  scab_ctrl2 i_dut (.mclk, .nrst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .first_phase, .second_phase, .sample_window, .comp_result, .phase_swap_select, .col_bus_oe,
    .comp_line_out, .comp_line_oe, .comp_latched, .offset_short_sw, .cap_to_gnd, .cap_to_amp,
    .sum_node_sw, .offset_cancel_enable, .c_branch_cap_size, .c_unit_en);
  function [7:0] adr(input integer k);
    adr = (k == 0) ? 8'h82 : (k == 1) ? 8'h8A : (k == 2) ? 8'h96 : 8'h9E;
  endfunction
  function [30:0] therm(input [4:0] n);
    therm = ~(31'h7FFFFFFF << n);
  endfunction
  task chk(input string what, input logic [30:0] exp, input logic [30:0] got);
    compares = compares + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // all strobes set in one place, once per edge
  task op(input w, input r, input [7:0] a, input [7:0] v);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= v;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk("read data", exp, reg_rdata);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #50000;
    mismatches = mismatches + 1;
    stop_test;
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    for (b = 0; b < 4; b = b + 1)
    begin
      shadow[b] = 8'h00;
      rd(adr(b), 8'h00);
    end
    chk("outputs", 31'h0, {col_bus_oe, comp_line_oe, sum_node_sw, c_branch_cap_size[18:0]});
    $display("reset test done");
    for (i = 0; i < 24; i = i + 1)
    begin
      b = $random(seed) & 3;
      d = (i < 2) ? {8{~i[0]}} : 8'($random(seed));
      phase_swap_select <= 4'($random(seed));
      op(1'b1, 1'b0, adr(b), d);
      shadow[b] = d;
      rd(adr(b), d);
      rd(adr(b) - 8'h01, 8'h00);
      chk("cap units", therm(d[4:0]), c_unit_en[31*b +: 31]);
      chk("fields", {d[6:5], d[5:0]}, {comp_line_oe[b], sum_node_sw[b], offset_cancel_enable[b],
        c_branch_cap_size[5*b +: 5]});
    end
    for (b = 0; b < 4; b = b + 1)
      rd(adr(b), shadow[b]);
    $display("register test done");
    for (i = 0; i < 3; i = i + 1)
    begin
      phase_swap_select <= {3'h0, i == 1};
      op(1'b1, 1'b0, 8'h82, (i == 2) ? 8'h60 : 8'hE0);
      op(1'b0, 1'b0, 8'h00, 8'h00);
      hits = 0;
      shorts = 0;
      gnds = 0;
      amps = 0;
      cmpbad = 0;
      repeat (64)
      begin
        @(posedge mclk);
        #1;
        hits = hits + col_bus_oe[0];
        shorts = shorts + offset_short_sw[0];
        gnds = gnds + cap_to_gnd[0];
        amps = amps + cap_to_amp[0];
        cmpbad = cmpbad + (comp_line_out[0] !== comp_latched[0]);
      end
      chk("bus cycles", (i == 0) ? 10 : (i == 1) ? 64 : 0, hits);
      chk("short cycles", 18, shorts);
      chk("ground cycles", 18, gnds);
      chk("amp cycles", 18, amps);
      chk("comparator line", 0, cmpbad);
    end
    $display("gating test done");
    stop_test;
  end
endmodule // test_sc_block_switch_control
